//--- logic/vcsd_pkg.sv
package vcsd_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int DATA_W = 10;
    localparam int ADDR_W = 12;
    localparam int REG_W  = 16;
    localparam int LINE_W = 11;
    localparam int WORD_W = 13;
    localparam int MASK_W = 10;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [ADDR_W-1:0] REG_FEATURE_MASK  = 12'h000;
    localparam logic [ADDR_W-1:0] REG_VIDEO_STD     = 12'h010;
    localparam logic [ADDR_W-1:0] REG_TOTAL_LINES   = 12'h011;
    localparam logic [ADDR_W-1:0] REG_TOTAL_WORDS   = 12'h012;
    localparam logic [ADDR_W-1:0] REG_ACTIVE_WORDS  = 12'h013;
    localparam logic [ADDR_W-1:0] REG_ACTIVE_LINES  = 12'h014;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int                LOCK_BIT          = 4;
    localparam logic [MASK_W-1:0] MASK_RESET        = 10'h000;
    localparam logic [REG_W-1:0]  READ_RESET        = 16'h0000;

    // ****************************************
    // Video word values and timing word layout
    // ****************************************
    localparam logic [DATA_W-1:0] BLANK_LUMA        = 10'h040;
    localparam logic [DATA_W-1:0] BLANK_CHROMA      = 10'h200;
    localparam logic [DATA_W-1:0] TRS_PREAMBLE      = 10'h3FF;
    localparam logic [DATA_W-1:0] TRS_ZERO          = 10'h000;
    localparam int                XYZ_F_BIT         = 8;
    localparam int                XYZ_V_BIT         = 7;
    localparam int                XYZ_H_BIT         = 6;
    localparam logic [WORD_W-1:0] TRS_LEAD_WORDS    = 13'h0003;

    // ****************************************
    // Counts of cycles and stages
    // ****************************************
    localparam int                PIPE_STAGES       = 4;
    localparam int                FIFO_DEPTH        = 16;
    localparam int                SYNC_STAGES       = 3;

endpackage : vcsd_pkg

//--- logic/vcsd_stream_if.sv
`timescale 1ns/1ps

// ****************************************
// Word stream with valid and ready
// ****************************************
interface vcsd_stream_if #(
    parameter int WIDTH = 10
);
    logic [WIDTH-1:0] data;
    logic             valid;
    logic             ready;

    // Producer drives word and valid
    modport source (output data, output valid, input ready);
    // Consumer drives ready
    modport sink   (input data, input valid, output ready);
endinterface : vcsd_stream_if

//--- logic/vcsd_fifo.sv
`timescale 1ns/1ps

module vcsd_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rstSync_n,
    // Stream sides
    vcsd_stream_if.sink    inPort,
    vcsd_stream_if.source  outPort
);

    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wrPtr;
    logic [PTR_W-1:0] rdPtr;
    logic [CNT_W-1:0] memCount;
    logic [CNT_W-1:0] next_memCount;
    logic             push;
    logic             pop;

    // ****************************************
    // Handshake terms
    // ****************************************
    // Head register refills when empty or drained this cycle
    assign push = inPort.valid && inPort.ready;
    assign pop  = (memCount != '0) && (!outPort.valid || outPort.ready);
    assign next_memCount = memCount + CNT_W'(push) - CNT_W'(pop);

    // Storage, written only on accepted words
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr] <= inPort.data;
        end
    end

    // Pointers wrap at depth so any depth works
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
        end else begin
            if (push) begin
                wrPtr <= (wrPtr == PTR_W'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
            end
            if (pop) begin
                rdPtr <= (rdPtr == PTR_W'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
            end
        end
    end

    // Fill level and registered ready, so back-pressure is one flop away
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            memCount     <= '0;
            inPort.ready <= 1'b0;
        end else begin
            memCount     <= next_memCount;
            inPort.ready <= next_memCount < DEPTH_C;
        end
    end

    // Output head register
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            outPort.valid <= 1'b0;
            outPort.data  <= '0;
        end else if (pop) begin
            outPort.valid <= 1'b1;
            outPort.data  <= mem[rdPtr];
        end else if (outPort.ready) begin
            outPort.valid <= 1'b0;
        end
    end

    AST_FIFO_BOUND: assert property (@(posedge clk) disable iff (!rstSync_n)
        memCount <= DEPTH_C)
        else $error("fifo fill level above depth");

endmodule : vcsd_fifo

//--- logic/vcsd_crop_detect.sv
`timescale 1ns/1ps

// Behaviour
// - Crop pin low blanks every incoming sample except TRS words
// - Crop blanks video and ancillary, never TRS
// - Crop pin high passes video unchanged
// - Detect standard from TRS or HVF timing
// - Lines per frame, 11 bits at 11h
// - Words per line, 13 bits at 12h
// - Active words per line, 13 bits, 13h
// - Active lines per field, 11 bits, 14h
// - Lock flag bit 4 when synchronized
// - Lock and raster zero in reset or bypass
// - Results held when video stops
// - Results cleared only by reset or bypass
// - Features only in SMPTE mode with enable
// - Feature mask resets to all zeros
// - SMPTE mode: scramble high, async low
// - Timing select low HVF, high TRS
module vcsd_crop_detect #(
    parameter int FIFO_DEPTH = vcsd_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                           clk,
    input  wire logic                           rst_n,
    // Parallel video in, pixel clock domain
    input  wire logic [vcsd_pkg::DATA_W-1:0]    dataIn,
    input  wire logic                           inValid,
    output wire logic                           inReady,
    input  wire logic                           videoCrop_n,
    input  wire logic                           hIn,
    input  wire logic                           vIn,
    input  wire logic                           fIn,
    // Mode pins, static straps
    input  wire logic                           scrambleModeSelect,
    input  wire logic                           asyncStreamSelect,
    input  wire logic                           extraProcessingEnable,
    input  wire logic                           embeddedTimingSelect,
    // Video out toward later stages
    output wire logic [vcsd_pkg::DATA_W-1:0]    outData,
    output wire logic                           outValid,
    input  wire logic                           outReady,
    // Host register port
    input  wire logic [vcsd_pkg::ADDR_W-1:0]    regAddr,
    input  wire logic                           regRead,
    input  wire logic                           regWrite,
    input  wire logic [vcsd_pkg::REG_W-1:0]     regWriteData,
    output logic      [vcsd_pkg::REG_W-1:0]     regReadData,
    output logic                                regReadValid,
    // Per-feature enables for insertion stages
    output logic      [vcsd_pkg::MASK_W-1:0]    featureEnable
);

    // ****************************************
    // Reset release and pin synchronisers
    // ****************************************
    logic                              rstMeta_n, rstSync_n;
    logic [3:0]                        pinMeta, pinMid, pinLate, pinLevel;
    logic                              scrambleOn, asyncOn, extraOn, embeddedOn, smpteMode;

    // Two-flop reset release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_n <= 1'b0;
            rstSync_n <= 1'b0;
        end else begin
            rstMeta_n <= 1'b1;
            rstSync_n <= rstMeta_n;
        end
    end

    // Straps cross three flops; a change counts once stages two and three agree
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            pinMeta  <= '0;
            pinMid   <= '0;
            pinLate  <= '0;
            pinLevel <= '0;
        end else begin
            pinMeta <= {scrambleModeSelect, asyncStreamSelect,
                        extraProcessingEnable, embeddedTimingSelect};
            pinMid  <= pinMeta;
            pinLate <= pinMid;
            for (int i = 0; i < 4; i++) begin
                if (pinMid[i] == pinLate[i]) begin
                    pinLevel[i] <= pinLate[i];
                end
            end
        end
    end

    assign scrambleOn = pinLevel[3];
    assign asyncOn    = pinLevel[2];
    assign extraOn    = pinLevel[1];
    assign embeddedOn = pinLevel[0];
    assign smpteMode  = scrambleOn && !asyncOn;

    // ****************************************
    // Four-word look-ahead for TRS protection
    // ****************************************
    // Crop pin is sampled directly: the source keeps it on the pixel clock
    vcsd_stream_if #(.WIDTH(vcsd_pkg::DATA_W)) toFifo ();
    vcsd_stream_if #(.WIDTH(vcsd_pkg::DATA_W)) fromFifo ();

    logic [vcsd_pkg::DATA_W-1:0]     pipeData [vcsd_pkg::PIPE_STAGES];
    logic [vcsd_pkg::PIPE_STAGES-1:0] pipeValid, pipeProt, pipeCrop;
    logic                             accept, trsHit, chromaNext, blankNow;
    logic [vcsd_pkg::DATA_W-1:0]      cropWord;

    assign accept = inValid && toFifo.ready;
    // Fourth word of a 3FF 000 000 XYZ run is arriving now
    assign trsHit = pipeValid[2] && pipeData[2] == vcsd_pkg::TRS_PREAMBLE
                 && pipeData[1] == vcsd_pkg::TRS_ZERO
                 && pipeData[0] == vcsd_pkg::TRS_ZERO;

    // Shift line advances only on accepted words; a stall freezes it
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            pipeValid <= '0;
            pipeProt  <= '0;
            pipeCrop  <= '0;
            for (int i = 0; i < vcsd_pkg::PIPE_STAGES; i++) begin
                pipeData[i] <= '0;
            end
        end else if (accept) begin
            pipeData[0] <= dataIn;
            pipeValid   <= {pipeValid[vcsd_pkg::PIPE_STAGES-2:0], 1'b1};
            pipeCrop    <= {pipeCrop[vcsd_pkg::PIPE_STAGES-2:0], !videoCrop_n};
            pipeProt[0] <= trsHit;
            for (int i = 1; i < vcsd_pkg::PIPE_STAGES; i++) begin
                pipeData[i] <= pipeData[i-1];
                pipeProt[i] <= pipeProt[i-1] || trsHit;
            end
        end
    end

    // Sample order restarts at Cb after every timing word
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            chromaNext <= 1'b1;
        end else if (toFifo.valid) begin
            chromaNext <= pipeProt[3] ? 1'b1 : !chromaNext;
        end
    end

    // Crop mux: timing words always win over the crop pin
    assign blankNow = pipeCrop[3] && !pipeProt[3];
    assign cropWord = !blankNow ? pipeData[3]
                    : (chromaNext ? vcsd_pkg::BLANK_CHROMA : vcsd_pkg::BLANK_LUMA);

    assign toFifo.valid = accept && pipeValid[3];
    assign toFifo.data  = cropWord;
    assign inReady      = toFifo.ready;
    assign outData      = fromFifo.data;
    assign outValid     = fromFifo.valid;
    assign fromFifo.ready = outReady;

    vcsd_fifo #(.WIDTH(vcsd_pkg::DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .rstSync_n (rstSync_n),
        .inPort    (toFifo),
        .outPort   (fromFifo)
    );

    // ****************************************
    // Timing extraction and raster measurement
    // ****************************************
    logic                            tH, tV, tF;
    logic                            nH, nV, nF;
    logic                            hRise, vRise, frameStart;
    logic [vcsd_pkg::WORD_W-1:0]     wordCount, activeCount, activeWords;
    logic [vcsd_pkg::LINE_W-1:0]     lineCount, activeLineCount, lineTotal, activeLineTotal;
    logic [vcsd_pkg::LINE_W-1:0]     totalLinesPerFrame, activeLinesPerField;
    logic [vcsd_pkg::WORD_W-1:0]     totalWordsPerLine, wordsPerActiveLine;
    logic                            standardLockedFlag;

    // Source of H, V and F: HVF pins, else the XYZ word, held between timing runs
    assign nH = !embeddedOn ? hIn : (trsHit ? dataIn[vcsd_pkg::XYZ_H_BIT] : tH);
    assign nV = !embeddedOn ? vIn : (trsHit ? dataIn[vcsd_pkg::XYZ_V_BIT] : tV);
    assign nF = !embeddedOn ? fIn : (trsHit ? dataIn[vcsd_pkg::XYZ_F_BIT] : tF);

    assign hRise      = nH && !tH;
    assign vRise      = nV && !tV;
    assign frameStart = !nV && tV && !nF; // First active line of field one
    assign lineTotal       = lineCount + vcsd_pkg::LINE_W'(hRise);
    assign activeLineTotal = activeLineCount + vcsd_pkg::LINE_W'(hRise && !tV);
    // Preamble of an EAV is counted as active in embedded mode; take it back
    assign activeWords = (embeddedOn && activeCount >= vcsd_pkg::TRS_LEAD_WORDS)
                       ? activeCount - vcsd_pkg::TRS_LEAD_WORDS : activeCount;

    // Running counters; idle input leaves them untouched
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            tH              <= 1'b0;
            tV              <= 1'b0;
            tF              <= 1'b0;
            wordCount       <= '0;
            activeCount     <= '0;
            lineCount       <= '0;
            activeLineCount <= '0;
        end else if (!scrambleOn) begin
            wordCount       <= '0;
            activeCount     <= '0;
            lineCount       <= '0;
            activeLineCount <= '0;
        end else if (accept) begin
            tH <= nH;
            tV <= nV;
            tF <= nF;
            wordCount   <= hRise ? vcsd_pkg::WORD_W'(1) : wordCount + 1'b1;
            activeCount <= hRise ? '0
                         : activeCount + vcsd_pkg::WORD_W'(!nH && (!tH || !embeddedOn));
            lineCount       <= frameStart ? '0 : lineTotal;
            activeLineCount <= (vRise || frameStart) ? '0 : activeLineTotal;
        end
    end

    // Measured raster, zero outside scrambling mode, held otherwise
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            totalLinesPerFrame  <= '0;
            totalWordsPerLine   <= '0;
            wordsPerActiveLine  <= '0;
            activeLinesPerField <= '0;
            standardLockedFlag  <= 1'b0;
        end else if (!scrambleOn) begin
            totalLinesPerFrame  <= '0;
            totalWordsPerLine   <= '0;
            wordsPerActiveLine  <= '0;
            activeLinesPerField <= '0;
            standardLockedFlag  <= 1'b0;
        end else if (accept) begin
            if (hRise) begin
                totalWordsPerLine  <= wordCount;
                wordsPerActiveLine <= activeWords;
            end
            if (vRise) begin
                activeLinesPerField <= activeLineTotal;
            end
            if (frameStart) begin
                totalLinesPerFrame <= lineTotal;
                // Two equal frames in a row with a sane line length mean lock
                standardLockedFlag <= lineTotal == totalLinesPerFrame
                                   && lineTotal != '0
                                   && totalWordsPerLine != '0;
            end
        end
    end

    // ****************************************
    // Feature mask and host register port
    // ****************************************
    logic [vcsd_pkg::MASK_W-1:0] featureOffMask;

    // Host sets a bit to switch one feature off
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            featureOffMask <= vcsd_pkg::MASK_RESET;
        end else if (regWrite && regAddr == vcsd_pkg::REG_FEATURE_MASK) begin
            featureOffMask <= regWriteData[vcsd_pkg::MASK_W-1:0];
        end
    end

    // Insertion features live only in SMPTE mode with the enable pin high
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            featureEnable <= '0;
        end else begin
            featureEnable <= (smpteMode && extraOn) ? ~featureOffMask : '0;
        end
    end

    // Read answer one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            regReadData  <= vcsd_pkg::READ_RESET;
            regReadValid <= 1'b0;
        end else begin
            regReadValid <= regRead;
            if (regRead) begin
                case (regAddr)
                    vcsd_pkg::REG_FEATURE_MASK: regReadData <= vcsd_pkg::REG_W'(featureOffMask);
                    vcsd_pkg::REG_VIDEO_STD:
                        regReadData <= vcsd_pkg::REG_W'(standardLockedFlag) << vcsd_pkg::LOCK_BIT;
                    vcsd_pkg::REG_TOTAL_LINES:  regReadData <= vcsd_pkg::REG_W'(totalLinesPerFrame);
                    vcsd_pkg::REG_TOTAL_WORDS:  regReadData <= vcsd_pkg::REG_W'(totalWordsPerLine);
                    vcsd_pkg::REG_ACTIVE_WORDS: regReadData <= vcsd_pkg::REG_W'(wordsPerActiveLine);
                    vcsd_pkg::REG_ACTIVE_LINES: regReadData <= vcsd_pkg::REG_W'(activeLinesPerField);
                    default:                    regReadData <= vcsd_pkg::READ_RESET;
                endcase
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstSync_n);

    sequence readOf(logic [vcsd_pkg::ADDR_W-1:0] a);
        regRead && regAddr == a;
    endsequence

    AST_CROP_BLANKS: assert property (toFifo.valid && pipeCrop[3] && !pipeProt[3]
        |-> toFifo.data == (chromaNext ? vcsd_pkg::BLANK_CHROMA : vcsd_pkg::BLANK_LUMA))
        else $error("cropped sample not at blanking level");
    AST_TRS_UNTOUCHED: assert property (toFifo.valid && pipeProt[3]
        |-> toFifo.data == pipeData[3])
        else $error("timing word altered by crop");
    AST_NO_CROP_PASS: assert property (toFifo.valid && !pipeCrop[3]
        |-> toFifo.data == pipeData[3])
        else $error("uncropped sample altered");
    AST_ZERO_IN_BYPASS: assert property (!scrambleOn |=> totalLinesPerFrame == '0
        && totalWordsPerLine == '0 && wordsPerActiveLine == '0
        && activeLinesPerField == '0 && !standardLockedFlag)
        else $error("raster results not cleared in bypass");
    AST_LOCK_NEEDS_RASTER: assert property (standardLockedFlag
        |-> totalLinesPerFrame != '0 && totalWordsPerLine != '0)
        else $error("lock without measured raster");
    AST_HOLD_WHEN_IDLE: assert property (!accept && scrambleOn ##1 scrambleOn
        |-> $stable(totalLinesPerFrame) && $stable(totalWordsPerLine)
            && $stable(standardLockedFlag))
        else $error("results changed without input");
    AST_FEATURE_GATE: assert property (!(smpteMode && extraOn) |=> featureEnable == '0)
        else $error("feature enabled outside SMPTE processing");
    AST_MASK_AFTER_RESET: assert property ($rose(rstSync_n) |-> featureOffMask == '0)
        else $error("feature mask not zero after reset");
    AST_READ_LINES: assert property (readOf(vcsd_pkg::REG_TOTAL_LINES)
        |=> regReadValid && regReadData == vcsd_pkg::REG_W'($past(totalLinesPerFrame)))
        else $error("line total read wrong");
    AST_READ_WORDS: assert property (readOf(vcsd_pkg::REG_TOTAL_WORDS)
        |=> regReadData == vcsd_pkg::REG_W'($past(totalWordsPerLine)))
        else $error("word total read wrong");
    AST_PIN_TIMING: assert property (!embeddedOn && accept && scrambleOn
        |=> tH == $past(hIn) && tV == $past(vIn))
        else $error("pin timing not followed");

endmodule : vcsd_crop_detect

//--- bench/vcsd_src_model.sv
`timescale 1ns/1ps

// Upstream video source, one word per handshake
module vcsd_src_model (
    // Clock and handshake
    input  wire logic       clk,
    input  wire logic       inReady,
    // Word toward the block
    output logic      [9:0] dataIn,
    output logic            inValid,
    output logic            videoCrop_n,
    // Words that timed out waiting for ready
    output int              stallCount
);
    initial begin
        stallCount = 0;
        dataIn = 10'h000;
        inValid = 1'b0;
        videoCrop_n = 1'b1;
    end

    // Crop held with its word on the pixel clock
    task automatic send(input logic [9:0] w, input logic crop_n);
        int n;
        @(posedge clk);
        dataIn <= w;
        videoCrop_n <= crop_n;
        inValid <= 1'b1;
        @(negedge clk);
        for (n = 0; n < 100 && inReady !== 1'b1; n++) @(negedge clk);
        if (inReady !== 1'b1) stallCount++;
        @(posedge clk);
        inValid <= 1'b0;
        dataIn <= ~w; // Released bus shows no stale word
    endtask : send
endmodule : vcsd_src_model

//--- bench/video_crop_and_std_detect_tb_top.sv
`timescale 1ns/1ps

module video_crop_and_std_detect_tb_top;
    // ****************************************
    // Signals
    // ****************************************
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic inReady, inValid, videoCrop_n, hIn, vIn, fIn, outValid, outReady;
    logic regRead, regWrite, regReadValid, scrambleModeSelect, asyncStreamSelect;
    logic extraProcessingEnable, embeddedTimingSelect;
    logic [9:0] dataIn, outData, featureEnable;
    logic [11:0] regAddr;
    logic [15:0] regWriteData, regReadData;
    logic [9:0] got[$];
    int bad_count = 0;
    int total_checks = 0;
    int stallCount;

    always #5 clk = ~clk;

    vcsd_crop_detect u_vcsd_crop_detect (.clk, .rst_n, .dataIn, .inValid, .inReady,
        .videoCrop_n, .hIn, .vIn, .fIn, .scrambleModeSelect, .asyncStreamSelect,
        .extraProcessingEnable, .embeddedTimingSelect, .outData, .outValid, .outReady,
        .regAddr, .regRead, .regWrite, .regWriteData, .regReadData, .regReadValid,
        .featureEnable);
    vcsd_src_model u_vcsd_src_model (.clk, .inReady, .dataIn, .inValid, .videoCrop_n,
        .stallCount);

    // Collect every word the sink takes
    always @(posedge clk) if (outValid === 1'b1 && outReady) got.push_back(outData);

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic reg_wr(input logic [11:0] a, input logic [15:0] v);
        @(posedge clk);
        regAddr <= a;
        regWriteData <= v;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [11:0] a, output logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        @(negedge clk);
        check("read strobe", 16'h0001, {15'h0000, regReadValid});
        d = regReadData;
    endtask : reg_rd

    task automatic reset_values();
        logic [15:0] d;
        logic [11:0] a[7] = '{12'h000, 12'h010, 12'h011, 12'h012, 12'h013, 12'h014, 12'h020};
        foreach (a[i]) begin
            reg_rd(a[i], d);
            check("reset register", 16'h0000, d);
        end
    endtask : reset_values

    task automatic mode_step(input logic asy, input logic ext, input logic [9:0] exp);
        @(posedge clk);
        asyncStreamSelect <= asy;
        extraProcessingEnable <= ext;
        repeat (8) @(posedge clk);
        @(negedge clk);
        check("enables", {6'h00, exp}, {6'h00, featureEnable});
    endtask : mode_step

    task automatic mask_and_mode();
        logic [15:0] d;
        reg_wr(12'h000, 16'h0005);
        reg_rd(12'h000, d);
        check("mask", 16'h0005, d);
        mode_step(1'b0, 1'b1, 10'h3FA);
        mode_step(1'b1, 1'b1, 10'h000);
        mode_step(1'b0, 1'b0, 10'h000);
        mode_step(1'b0, 1'b1, 10'h3FA);
    endtask : mask_and_mode

    task automatic crop_stream();
        logic [9:0] w[16] = '{10'h3FF, 10'h000, 10'h000, 10'h274, 10'h111, 10'h222,
            10'h333, 10'h0AB, 10'h111, 10'h222, 10'h333, 10'h0AB, 10'h155, 10'h155,
            10'h155, 10'h155};
        logic [9:0] e[12] = '{10'h3FF, 10'h000, 10'h000, 10'h274, 10'h200, 10'h040,
            10'h200, 10'h040, 10'h111, 10'h222, 10'h333, 10'h0AB};
        int n;
        got.delete();
        // Crop low over the timing run too, which must survive
        foreach (w[i]) u_vcsd_src_model.send(w[i], (i > 7));
        for (n = 0; n < 100 && got.size() < 12; n++) @(posedge clk);
        check("word count", 16'd12, 16'(got.size()));
        foreach (e[i]) check("word", {6'h00, e[i]}, {6'h00, got[i]});
    endtask : crop_stream

    task automatic raster();
        logic [15:0] d;
        logic [15:0] exp[5] = '{16'h0005, 16'h0006, 16'h0004, 16'h0003, 16'h0010};
        logic [11:0] a[5] = '{12'h011, 12'h012, 12'h013, 12'h014, 12'h010};
        @(posedge clk);
        embeddedTimingSelect <= 1'b0;
        repeat (8) @(posedge clk);
        // Three frames of five six-word lines, two lines of vertical blanking each
        for (int n = 0; n < 90; n++) begin
            hIn <= (n % 6) < 2;
            vIn <= (n % 30) < 12;
            u_vcsd_src_model.send(10'h100, 1'b1);
        end
        repeat (4) @(posedge clk);
        foreach (a[i]) begin
            reg_rd(a[i], d);
            check("raster register", exp[i], d);
        end
        @(posedge clk);
        scrambleModeSelect <= 1'b0;
        repeat (8) @(posedge clk);
        reg_rd(12'h010, d);
        check("lock in bypass", 16'h0000, d);
    endtask : raster

    task automatic end_sim();
        check("source stalls", 16'h0000, 16'(stallCount));
        $display("Checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    // ****************************************
    // Sequence and watchdog
    // ****************************************
    initial begin
        {hIn, vIn, fIn, regRead, regWrite, asyncStreamSelect} = 6'h00;
        {outReady, scrambleModeSelect, extraProcessingEnable, embeddedTimingSelect} = 4'hF;
        regAddr = 12'h000;
        regWriteData = 16'h0000;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (12) @(posedge clk);
        check("ready after reset", 16'h0001, {15'h0000, inReady});
        reset_values();
        mask_and_mode();
        crop_stream();
        raster();
        end_sim();
    end

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        end_sim();
    end
endmodule : video_crop_and_std_detect_tb_top
